// file: src/lsu_pkg.sv
// package for the load/store unit: opcodes, address windows, cycle counts
// assumes a single 40 MHz core clock, data reads that answer at once and registered program reads
package lsu_pkg;
  // operation codes presented on the issue port
  typedef enum logic [3:0] {
    op_read_absolute   = 4'h0,
    op_read_pointer    = 4'h1,
    op_read_post_inc   = 4'h2,
    op_read_pre_dec    = 4'h3,
    op_read_offset     = 4'h4,
    op_write_absolute  = 4'h5,
    op_write_pointer   = 4'h6,
    op_write_post_inc  = 4'h7,
    op_write_pre_dec   = 4'h8,
    op_write_offset    = 4'h9,
    op_code_read_r0    = 4'ha,
    op_code_read       = 4'hb,
    op_code_read_inc   = 4'hc,
    op_code_read_ext   = 4'hd
  } op_t;

  // pointer select
  typedef enum logic [1:0] {
    ptr_x = 2'h0,
    ptr_y = 2'h1,
    ptr_z = 2'h2
  } ptr_sel_t;

  typedef enum logic [1:0] {
    st_idle   = 2'h0,
    st_access = 2'h1,
    st_code   = 2'h2,
    st_finish = 2'h3
  } state_t;

  // register indices of pointer low bytes (high byte at index + 1), and of r0
  localparam logic [4:0] x_low_index = 5'h1a;
  localparam logic [4:0] y_low_index = 5'h1c;
  localparam logic [4:0] z_low_index = 5'h1e;
  localparam logic [4:0] r0_index    = 5'h00;

  // data-space windows
  localparam logic [15:0] nvm_window_base = 16'h1000;
  localparam logic [15:0] nvm_window_last = 16'h1fff;
  localparam logic [15:0] sram_base       = 16'h2000;

  // cycle counts per form
  localparam logic [1:0] cycles_one   = 2'h1;
  localparam logic [1:0] cycles_two   = 2'h2;
  localparam logic [1:0] cycles_three = 2'h3;

  localparam logic [7:0]  reg_reset  = 8'h00;
  localparam logic [7:0]  page_reset = 8'h00;
endpackage : lsu_pkg

// file: src/load_store_unit.sv
// load/store execution unit with its own 32 x 8 register file
// assumes data reads answer at once, program reads one cycle later
// assumes issue is ignored while busy is high
module load_store_unit (
  input  wire logic               clock,        // core clock, 40 MHz
  input  wire logic               rst_n,        // synchronous reset
  input  wire logic               issue,        // start an operation
  input  wire lsu_pkg::op_t       op,           // operation code
  input  wire lsu_pkg::ptr_sel_t  ptr_sel,      // pointer select
  input  wire logic [4:0]         reg_index,    // dest or source register
  input  wire logic [15:0]        abs_address,  // absolute address k
  input  wire logic [5:0]         disp,         // displacement q
  input  wire logic [7:0]         page_in,      // code page extension value
  input  wire logic               page_write,   // load code page extension
  input  wire logic [7:0]         data_rdata,   // data memory read data
  input  wire logic [7:0]         code_rdata,   // program memory read byte
  output logic                    busy,         // operation in progress
  output logic                    done,         // last cycle pulse
  output logic [15:0]             data_addr,    // data-space address
  output logic                    data_rd,      // data read strobe
  output logic                    data_wr,      // data write strobe
  output logic [7:0]              data_wdata,   // data write byte
  output logic                    sram_sel,     // access targets sram
  output logic                    nvm_sel,      // access targets nv memory
  output logic                    io_sel,       // access targets i/o space
  output logic [23:0]             code_addr,    // program byte address
  output logic                    code_rd,      // program read strobe
  output logic [7:0]              status_flags  // flags, never changed
);
  logic [7:0] regs [32];
  logic [7:0] next_regs [32];
  logic [7:0] page, next_page;
  lsu_pkg::state_t state, next_state;
  logic [1:0] count, next_count;
  logic [4:0] dest, next_dest;
  logic       is_code, next_is_code;
  logic       next_busy, next_done, next_data_rd, next_data_wr;
  logic       next_code_rd, next_sram_sel, next_nvm_sel, next_io_sel;
  logic [15:0] next_data_addr;
  logic [7:0]  next_data_wdata;
  logic [23:0] next_code_addr;

  // pointer low-byte index for a selection
  function automatic logic [4:0] ptr_base(input lsu_pkg::ptr_sel_t s);
    unique case (s)
      lsu_pkg::ptr_x: ptr_base = lsu_pkg::x_low_index;
      lsu_pkg::ptr_y: ptr_base = lsu_pkg::y_low_index;
      default:        ptr_base = lsu_pkg::z_low_index;
    endcase
  endfunction : ptr_base

  // read a 16-bit pointer from its register pair
  // low byte first; the high byte sits one index above it
  function automatic logic [15:0] ptr_value(input logic [7:0] r [32],
                                            input logic [4:0] lo);
    ptr_value = {r[5'(lo + 5'h01)], r[lo]};
  endfunction : ptr_value

  // selected pointer, shared by the pointer-based data-space forms
  logic [4:0]  plo;
  logic [15:0] pval;
  assign plo  = ptr_base(ptr_sel);
  assign pval = ptr_value(regs, plo);

  // next-state computation for the whole unit
  always_comb
  begin
    logic [15:0] ea;
    logic [15:0] newp;
    logic        wp;
    logic        dacc;
    ea = 16'h0000;
    newp = pval;
    wp = 1'b0;
    dacc = 1'b0;
    // strobes and done are pulses; everything else holds by default
    next_regs = regs;
    next_page = page;
    next_state = state;
    next_count = count;
    next_dest = dest;
    next_is_code = is_code;
    next_busy = busy;
    next_done = 1'b0;
    next_data_rd = 1'b0;
    next_data_wr = 1'b0;
    next_code_rd = 1'b0;
    next_data_addr = data_addr;
    next_data_wdata = data_wdata;
    next_code_addr = code_addr;
    next_sram_sel = sram_sel;
    next_nvm_sel = nvm_sel;
    next_io_sel = io_sel;
    if (page_write)
    begin
      next_page = page_in;
    end
    // the state encoding is full, so no default branch is needed
    unique case (state)
      lsu_pkg::st_idle:
      begin
        if (issue)
        begin
          next_dest = reg_index;
          next_is_code = 1'b0;
          dacc = 1'b1;
          next_count = lsu_pkg::cycles_two;
          unique case (op)
            lsu_pkg::op_read_absolute, lsu_pkg::op_write_absolute:
              ea = abs_address;
            lsu_pkg::op_read_pointer, lsu_pkg::op_write_pointer:
            begin
              ea = pval;
              next_count = lsu_pkg::cycles_one;
            end
            lsu_pkg::op_read_post_inc, lsu_pkg::op_write_post_inc:
            begin
              ea = pval;
              newp = pval + 16'h0001;
              wp = 1'b1;
              next_count = lsu_pkg::cycles_one;
            end
            lsu_pkg::op_read_pre_dec, lsu_pkg::op_write_pre_dec:
            begin
              newp = pval - 16'h0001;
              ea = newp;
              wp = 1'b1;
            end
            lsu_pkg::op_read_offset, lsu_pkg::op_write_offset:
              ea = pval + {10'h000, disp};
            default:
            begin
              // program memory forms always use Z
              dacc = 1'b0;
              next_is_code = 1'b1;
              next_count = lsu_pkg::cycles_three;
              newp = ptr_value(regs, lsu_pkg::z_low_index);
              next_code_addr = {8'h00, newp};
              if (op == lsu_pkg::op_code_read_ext)
              begin
                next_code_addr = {page, newp};
                next_dest = lsu_pkg::r0_index;
              end
              if (op == lsu_pkg::op_code_read_r0)
              begin
                next_dest = lsu_pkg::r0_index;
              end
              if (op == lsu_pkg::op_code_read_inc)
              begin
                newp = newp + 16'h0001;
                next_regs[lsu_pkg::z_low_index] = newp[7:0];
                next_regs[lsu_pkg::z_low_index + 5'h01] = newp[15:8];
              end
              next_code_rd = 1'b1;
            end
          endcase
          // pointer write-back and strobes all leave at the issue edge,
          // so the next issue already sees an updated pointer
          if (dacc)
          begin
            if (wp)
            begin
              next_regs[plo] = newp[7:0];
              next_regs[5'(plo + 5'h01)] = newp[15:8];
            end
            next_data_addr = ea;
            // decode target window
            next_nvm_sel = (ea >= lsu_pkg::nvm_window_base) &&
                           (ea <= lsu_pkg::nvm_window_last);
            next_sram_sel = (ea >= lsu_pkg::sram_base);
            next_io_sel = (ea < lsu_pkg::nvm_window_base);
            if (op >= lsu_pkg::op_write_absolute)
            begin
              next_data_wr = 1'b1;
              next_data_wdata = regs[reg_index];
            end
            else
            begin
              next_data_rd = 1'b1;
            end
          end
          next_busy = 1'b1;
          next_state = next_is_code ? lsu_pkg::st_code
                                    : lsu_pkg::st_access;
          // a one-cycle form signals done together with busy
          if (next_count == lsu_pkg::cycles_one)
          begin
            next_done = 1'b1;
          end
        end
      end
      lsu_pkg::st_access:
      begin
        // data memory answers while the strobe stands; writes skip this
        if (!data_wr)
        begin
          next_regs[dest] = data_rdata;
        end
        if (count == lsu_pkg::cycles_two)
        begin
          next_state = lsu_pkg::st_finish;
          next_done = 1'b1;
        end
        else
        begin
          next_state = lsu_pkg::st_idle;
          next_busy = 1'b0;
          next_sram_sel = 1'b0;
          next_nvm_sel = 1'b0;
          next_io_sel = 1'b0;
        end
      end
      lsu_pkg::st_code:
      begin
        // first pass waits for the registered program byte, second pass
        // captures it; the count stands in for a state the encoding lacks
        if (count == lsu_pkg::cycles_three)
        begin
          next_count = lsu_pkg::cycles_two;
        end
        else
        begin
          next_regs[dest] = code_rdata;
          next_state = lsu_pkg::st_finish;
          next_done = 1'b1;
        end
      end
      lsu_pkg::st_finish:
      begin
        // selects drop together with busy
        next_state = lsu_pkg::st_idle;
        next_busy = 1'b0;
        next_sram_sel = 1'b0;
        next_nvm_sel = 1'b0;
        next_io_sel = 1'b0;
      end
    endcase
  end

  // all state registers; flags register is written only by reset, to zero
  // the register file resets too, so untouched registers read zero
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < 32; i++)
      begin
        regs[i] <= lsu_pkg::reg_reset;
      end
      page <= lsu_pkg::page_reset;
      state <= lsu_pkg::st_idle;
      count <= 2'h0;
      dest <= 5'h00;
      is_code <= 1'b0;
      busy <= 1'b0;
      done <= 1'b0;
      data_rd <= 1'b0;
      data_wr <= 1'b0;
      code_rd <= 1'b0;
      data_addr <= 16'h0000;
      data_wdata <= 8'h00;
      code_addr <= 24'h000000;
      sram_sel <= 1'b0;
      nvm_sel <= 1'b0;
      io_sel <= 1'b0;
      status_flags <= 8'h00;
    end
    else
    begin
      regs <= next_regs;
      page <= next_page;
      state <= next_state;
      count <= next_count;
      dest <= next_dest;
      is_code <= next_is_code;
      busy <= next_busy;
      done <= next_done;
      data_rd <= next_data_rd;
      data_wr <= next_data_wr;
      code_rd <= next_code_rd;
      data_addr <= next_data_addr;
      data_wdata <= next_data_wdata;
      code_addr <= next_code_addr;
      sram_sel <= next_sram_sel;
      nvm_sel <= next_nvm_sel;
      io_sel <= next_io_sel;
      status_flags <= status_flags;
    end
  end
endmodule : load_store_unit

// file: tb/load_store_unit_chk.sv
// checker: cycle counts, strobes and window decode of the unit's ports
// assumes it is bound to load_store_unit with one clock domain
module load_store_unit_chk (
  input wire logic              clock, rst_n, issue,  // clock, reset, start
  input wire lsu_pkg::op_t      op,                   // operation code
  input wire logic [15:0]       abs_address,          // absolute address
  input wire logic              busy, done,           // progress flags
  input wire logic [15:0]       data_addr,            // data address
  input wire logic              data_rd, data_wr,     // data strobes
  input wire logic              sram_sel, nvm_sel,    // window decode
  input wire logic              io_sel, code_rd,      // i/o, code strobe
  input wire logic [7:0]        status_flags          // flags
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  logic take, one_op, two_op, code_op;
  // classify the accepted operation by its length
  assign take = issue && !busy;
  assign one_op = op inside {lsu_pkg::op_read_pointer,
    lsu_pkg::op_read_post_inc, lsu_pkg::op_write_pointer,
    lsu_pkg::op_write_post_inc};
  assign code_op = op >= lsu_pkg::op_code_read_r0;
  assign two_op = !one_op && !code_op;
  flags_zero_a: assert property (
    status_flags == 8'h00) else $error("flags changed");
  one_cycle_a: assert property (
    take && one_op |=> busy && done ##1 !busy)
    else $error("one cycle form wrong");
  two_cycle_a: assert property (
    take && two_op |=> busy && !done ##1 busy && done ##1 !busy)
    else $error("two cycle form wrong");
  code_cycle_a: assert property (
    take && code_op |=> busy && code_rd && !data_rd ##1 busy && !done
    ##1 busy && done ##1 !busy)
    else $error("code read timing wrong");
  abs_read_a: assert property (
    take && op == lsu_pkg::op_read_absolute
    |=> data_rd && data_addr == $past(abs_address))
    else $error("absolute read address wrong");
  abs_write_a: assert property (
    take && op == lsu_pkg::op_write_absolute
    |=> data_wr && data_addr == $past(abs_address))
    else $error("absolute write address wrong");
  nvm_map_a: assert property (
    data_rd || data_wr |-> nvm_sel == (data_addr inside
    {[16'h1000:16'h1fff]})) else $error("nvm decode wrong");
  sram_map_a: assert property (
    data_rd || data_wr |-> sram_sel == (data_addr >= 16'h2000))
    else $error("sram decode wrong");
  strobe_pulse_a: assert property (
    data_rd || data_wr |=> !data_rd && !data_wr)
    else $error("strobe longer than one cycle");
endmodule : load_store_unit_chk
bind load_store_unit load_store_unit_chk i_load_store_unit_chk (.*);

// file: tb/lsu_mem_model.sv
// data memory array and address-derived program bytes facing the unit
// assumes registered strobes; data answers at once, code a cycle later
module lsu_mem_model (
  input  wire logic        clock,       // core clock
  input  wire logic [15:0] data_addr,   // data address
  input  wire logic        data_rd,     // data read strobe
  input  wire logic        data_wr,     // data write strobe
  input  wire logic [7:0]  data_wdata,  // write byte
  input  wire logic [23:0] code_addr,   // program address
  input  wire logic        code_rd,     // program read strobe
  output logic      [7:0]  data_rdata,  // read byte
  output logic      [7:0]  code_rdata   // program byte
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [0:65535];
  logic [1:0] ch = 2'h0;
  initial code_rdata = 8'h00;
  // data reads answer while the strobe stands; outside it the byte is
  // inverted so a sample in the wrong cycle cannot pass by luck
  assign data_rdata = data_rd ? mem[data_addr] : ~mem[data_addr];
  // program bytes are registered and held three cycles, then churn
  always @(posedge clock)
  begin
    if (data_wr) mem[data_addr] <= data_wdata;
    if (code_rd)
    begin
      code_rdata <= code_addr[7:0] ^ code_addr[15:8] ^ code_addr[23:16]
        ^ 8'h5a;
      ch <= 2'h2;
    end
    else if (ch != 2'h0) ch <= ch - 2'h1;
    else code_rdata <= ~code_rdata;
  end
endmodule : lsu_mem_model

// file: tb/load_store_unit_tb.sv
// bench for the load/store unit: every addressing form and window
// assumes the memory model answers; register file seen via stores
module load_store_unit_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 0, rst_n = 0, issue = 0, page_write = 0;
  lsu_pkg::op_t op = lsu_pkg::op_read_absolute;
  lsu_pkg::ptr_sel_t ptr_sel = lsu_pkg::ptr_z;
  logic [4:0] reg_index = 5'h00;
  logic [15:0] abs_address = 16'h0000, data_addr;
  logic [5:0] disp = 6'h00;
  logic [7:0] page_in = 8'h00, data_rdata, code_rdata, data_wdata;
  logic [7:0] status_flags, seen_wd;
  logic [23:0] code_addr, seen_ad;
  logic busy, done, data_rd, data_wr, sram_sel, nvm_sel, io_sel, code_rd;
  logic [2:0] seen_sel;
  int err_total = 0, checked = 0, cyc;
  always #12.5 clock = ~clock;
  load_store_unit i_load_store_unit (.*);
  lsu_mem_model i_lsu_mem_model (.*);
  task close_out;
    $display("checked %0d err_total %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : close_out
  task cmp(string what, logic [23:0] e, logic [23:0] s);
    checked++;
    if (s !== e)
    begin
      err_total++;
      $display("FAIL %s expected %h seen %h", what, e, s);
    end
  endtask : cmp
  // one issue; captures the access cycle and counts busy cycles
  task xfer(lsu_pkg::op_t o, lsu_pkg::ptr_sel_t p, logic [4:0] r,
            logic [15:0] k, logic [5:0] q, logic [23:0] ea, int ec);
    @(negedge clock);
    op = o; ptr_sel = p; reg_index = r; abs_address = k; disp = q;
    issue = 1;
    @(negedge clock);
    issue = 0;
    seen_ad = code_rd ? code_addr : {8'h00, data_addr};
    seen_wd = data_wdata;
    seen_sel = {io_sel, nvm_sel, sram_sel};
    cyc = 0;
    while (busy === 1'b1 && cyc < 8) begin cyc++; @(negedge clock); end
    if (cyc == 8) begin err_total++; close_out(); end
    cmp("address", ea, seen_ad);
    if (ec > 0) cmp("cycles", 24'(ec), 24'(cyc));
  endtask : xfer
  task t_abs;
    xfer(lsu_pkg::op_read_absolute, lsu_pkg::ptr_z, 5'h1e, 16'h2010,
      6'h00, 24'h2010, 2);
    cmp("sram", 3'b001, seen_sel);
    xfer(lsu_pkg::op_read_absolute, lsu_pkg::ptr_z, 5'h1f, 16'h2011,
      6'h00, 24'h2011, 2);
    xfer(lsu_pkg::op_write_absolute, lsu_pkg::ptr_z, 5'h1f, 16'h0040,
      6'h00, 24'h0040, 2);
    cmp("io data", 8'h21, seen_wd);
  endtask : t_abs
  task t_ptr;
    xfer(lsu_pkg::op_write_pointer, lsu_pkg::ptr_z, 5'h1e, 16'h0,
      6'h00, 24'h2134, 1);
    cmp("z data", 8'h34, seen_wd);
    xfer(lsu_pkg::op_write_post_inc, lsu_pkg::ptr_z, 5'h00, 16'h0,
      6'h00, 24'h2134, 1);
    xfer(lsu_pkg::op_read_post_inc, lsu_pkg::ptr_z, 5'h02, 16'h0,
      6'h00, 24'h2135, 1);
    xfer(lsu_pkg::op_read_pointer, lsu_pkg::ptr_z, 5'h02, 16'h0,
      6'h00, 24'h2136, 1);
    xfer(lsu_pkg::op_write_pointer, lsu_pkg::ptr_x, 5'h02, 16'h0,
      6'h00, 24'h0000, 1);
  endtask : t_ptr
  task t_dec;
    xfer(lsu_pkg::op_read_pre_dec, lsu_pkg::ptr_z, 5'h05, 16'h0,
      6'h00, 24'h2135, 2);
    xfer(lsu_pkg::op_write_absolute, lsu_pkg::ptr_z, 5'h05, 16'h1800,
      6'h00, 24'h1800, 2);
    cmp("loaded", 8'ha7, seen_wd);
    cmp("nvm", 3'b010, seen_sel);
    xfer(lsu_pkg::op_write_pre_dec, lsu_pkg::ptr_z, 5'h05, 16'h0,
      6'h00, 24'h2134, 2);
  endtask : t_dec
  task t_off;
    xfer(lsu_pkg::op_read_offset, lsu_pkg::ptr_z, 5'h06, 16'h0,
      6'h03, 24'h2137, 2);
    xfer(lsu_pkg::op_write_offset, lsu_pkg::ptr_z, 5'h06, 16'h0,
      6'h3f, 24'h2173, 2);
    cmp("offset data", 8'h5c, seen_wd);
    xfer(lsu_pkg::op_read_offset, lsu_pkg::ptr_y, 5'h06, 16'h0,
      6'h05, 24'h0005, 2);
  endtask : t_off
  task t_code;
    xfer(lsu_pkg::op_code_read_inc, lsu_pkg::ptr_z, 5'h07, 16'h0,
      6'h00, 24'h002134, 3);
    xfer(lsu_pkg::op_code_read, lsu_pkg::ptr_x, 5'h08, 16'h0,
      6'h00, 24'h002135, 3);
    xfer(lsu_pkg::op_write_absolute, lsu_pkg::ptr_z, 5'h07, 16'h2200,
      6'h00, 24'h2200, 2);
    cmp("code byte", 8'h21 ^ 8'h34 ^ 8'h5a, seen_wd);
    @(negedge clock);
    page_in = 8'h05;
    page_write = 1;
    @(negedge clock);
    page_write = 0;
    xfer(lsu_pkg::op_code_read_r0, lsu_pkg::ptr_z, 5'h09, 16'h0,
      6'h00, 24'h002135, 3);
    xfer(lsu_pkg::op_code_read_ext, lsu_pkg::ptr_z, 5'h09, 16'h0,
      6'h00, 24'h052135, 3);
    xfer(lsu_pkg::op_write_absolute, lsu_pkg::ptr_z, 5'h00, 16'h2201,
      6'h00, 24'h2201, 2);
    cmp("ext byte", 8'h05 ^ 8'h21 ^ 8'h35 ^ 8'h5a, seen_wd);
  endtask : t_code
  // preload the data bytes the absolute and pointer scenarios read back
  initial
  begin
    i_lsu_mem_model.mem[16'h2010] = 8'h34;
    i_lsu_mem_model.mem[16'h2011] = 8'h21;
    i_lsu_mem_model.mem[16'h2135] = 8'ha7;
    i_lsu_mem_model.mem[16'h2137] = 8'h5c;
    repeat (16) @(negedge clock);
    rst_n = 1;
    t_abs();
    t_ptr();
    t_dec();
    t_off();
    t_code();
    cmp("flags", 8'h00, status_flags);
    close_out();
  end
endmodule : load_store_unit_tb
